// file: hw/ebp_pin_mux.sv
// Pin multiplexer joining static and sdram controllers onto the external bus port
`timescale 1ns/1ps
`default_nettype none
`include "ebp_map.svh"
module ebp_pin_mux
    import ebp_pkg::*;
(
    // Clock and reset
    input  wire logic                        mclk_i,
    input  wire logic                        rst_b_i,
    // Configuration
    input  wire logic                        bus_wide_i,
    // Ownership
    input  wire logic                        static_own_i,
    input  wire logic                        sdram_own_i,
    // Static memory controller side
    input  wire logic [`EBP_ADDR_W-1:0]      stc_addr_i,
    input  wire logic [`EBP_NCS-1:0]         stc_chip_select_n_i,
    input  wire logic                        stc_read_strobe_n_i,
    input  wire logic [3:0]                  stc_byte_write_n_i,
    input  wire logic                        stc_upper_byte_n_i,
    input  wire logic                        stc_lower_byte_n_i,
    input  wire logic [`EBP_DATA_W-1:0]      stc_wdata_i,
    input  wire logic                        stc_drive_i,
    input  wire logic                        stc_nand_en_i,
    input  wire logic                        stc_card_en_i,
    input  wire logic                        stc_card_rd_i,
    output logic      [`EBP_DATA_W-1:0]      stc_rdata_o,
    output logic                             stc_ext_wait_n_o,
    // Sdram controller side
    input  wire logic [`EBP_SDR_ADDR_W-1:0]  sdc_addr_i,
    input  wire logic [1:0]                  sdc_bank_i,
    input  wire logic [3:0]                  sdc_byte_mask_n_i,
    input  wire logic                        sdc_sel_n_i,
    input  wire logic                        sdc_ras_n_i,
    input  wire logic                        sdc_cas_n_i,
    input  wire logic                        sdc_we_n_i,
    input  wire logic                        sdc_clk_en_i,
    input  wire logic [`EBP_DATA_W-1:0]      sdc_wdata_i,
    input  wire logic                        sdc_drive_i,
    output logic      [`EBP_DATA_W-1:0]      sdc_rdata_o,
    // Shared pins
    output logic      [`EBP_ADDR_W-1:0]      pin_addr_o,
    output logic      [`EBP_DATA_W-1:0]      pin_data_o,
    output logic      [`EBP_DATA_W-1:0]      pin_data_oe_o,
    input  wire logic [`EBP_DATA_W-1:0]      pin_data_i,
    input  wire logic                        pin_ext_wait_n_i,
    output logic      [`EBP_NCS-1:0]         pin_chip_select_n_o,
    output logic                             pin_read_strobe_n_o,
    output logic      [3:0]                  pin_byte_write_n_o,
    // Dedicated pins
    output logic                             pin_sdram_addr_bit10_o,
    output logic                             pin_sdram_ras_n_o,
    output logic                             pin_sdram_cas_n_o,
    output logic                             pin_sdram_we_n_o,
    output logic                             pin_sdram_clk_en_o,
    output logic                             pin_nand_out_en_n_o,
    output logic                             pin_nand_wr_en_n_o,
    output logic                             pin_card_io_read_n_o,
    output logic                             pin_card_io_write_n_o,
    output logic                             pin_card_read_not_write_o
);
    // =========================================================
    // Ownership
    ebp_owner_e owner;
    always_comb begin
        // Sdram wins a double claim; the arbiter should never allow one
        if (sdram_own_i) begin
            owner = EBP_OWN_SDRAM;
        end else if (static_own_i) begin
            owner = EBP_OWN_STATIC;
        end else begin
            owner = EBP_OWN_NONE;
        end
    end

    // =========================================================
    // Next pin values
    logic [`EBP_ADDR_W-1:0] next_addr;
    logic [`EBP_DATA_W-1:0] next_data;
    logic [`EBP_DATA_W-1:0] next_data_oe;
    logic [`EBP_DATA_W-1:0] width_mask;
    logic [`EBP_NCS-1:0]    next_cs_n;
    logic                   next_rd_n;
    logic [3:0]             next_wr_n;
    logic                   next_a10;
    logic [3:0]             next_sdr;
    logic [1:0]             next_nand;
    logic [2:0]             next_card;

    // Narrow bus leaves upper lanes undriven
    assign width_mask = bus_wide_i ? '1 : `EBP_HALF_MASK;

    always_comb begin
        // Idle levels first, so an unowned pin never strobes
        next_addr    = '0;
        next_data    = '0;
        next_data_oe = '0;
        next_cs_n    = `EBP_CS_IDLE;
        next_rd_n    = 1'b1;
        next_wr_n    = `EBP_MASK_IDLE;
        next_a10     = 1'b0;
        next_sdr     = `EBP_SDR_IDLE;
        next_nand    = `EBP_NAND_IDLE;
        next_card    = `EBP_CARD_IDLE;
        case (owner)
            EBP_OWN_STATIC: begin
                next_addr    = stc_addr_i;
                next_addr[0] = stc_addr_i[0] & stc_lower_byte_n_i;
                next_data    = stc_wdata_i & width_mask;
                next_data_oe = stc_drive_i ? width_mask : '0;
                next_cs_n    = stc_chip_select_n_i;
                next_rd_n    = stc_read_strobe_n_i;
                next_wr_n    = stc_byte_write_n_i;
                next_wr_n[1] = stc_byte_write_n_i[1] & stc_upper_byte_n_i;
                if (stc_nand_en_i) begin
                    next_nand = {stc_read_strobe_n_i, stc_byte_write_n_i[0]};
                end
                if (stc_card_en_i) begin
                    next_card = {stc_read_strobe_n_i, stc_byte_write_n_i[0], stc_card_rd_i};
                end
            end
            EBP_OWN_SDRAM: begin
                next_addr[11:2]  = sdc_addr_i[9:0];
                next_addr[14:13] = sdc_addr_i[12:11];
                // Bank select rides on address pins sixteen and seventeen
                next_addr[17:16] = sdc_bank_i;
                next_addr[0]     = sdc_byte_mask_n_i[0];
                next_addr[1]     = sdc_byte_mask_n_i[2];
                next_wr_n        = sdc_byte_mask_n_i;
                next_a10         = sdc_addr_i[10];
                next_cs_n[`EBP_SEL_SDRAM] = sdc_sel_n_i;
                next_sdr  = {sdc_ras_n_i, sdc_cas_n_i, sdc_we_n_i, sdc_clk_en_i};
                next_data    = sdc_wdata_i & width_mask;
                next_data_oe = sdc_drive_i ? width_mask : '0;
            end
            default: begin
            end
        endcase
    end

    // =========================================================
    // Registered outputs
    // Address and data fall to zero when nobody owns the bus
    ebp_out_reg #(.W(`EBP_ADDR_W)) u_addr (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     (next_addr),
        .q_o     (pin_addr_o)
    );

    ebp_out_reg #(.W(`EBP_DATA_W)) u_data (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     (next_data),
        .q_o     (pin_data_o)
    );

    // Enable per lane, so a narrow bus leaves the upper half released
    ebp_out_reg #(.W(`EBP_DATA_W)) u_data_oe (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     (next_data_oe),
        .q_o     (pin_data_oe_o)
    );

    // Card selects share pins four and five with the general selects
    ebp_out_reg #(.W(`EBP_NCS), .IDLE(`EBP_CS_IDLE)) u_cs (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     (next_cs_n),
        .q_o     (pin_chip_select_n_o)
    );

    // Read strobe and byte writes leave reset high together
    ebp_out_reg #(.W(5), .IDLE(`EBP_STROBE_IDLE)) u_strobe (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({next_rd_n, next_wr_n}),
        .q_o     ({pin_read_strobe_n_o, pin_byte_write_n_o})
    );

    // Address ten is sdram only; static accesses keep it low
    ebp_out_reg #(.W(1)) u_a10 (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     (next_a10),
        .q_o     (pin_sdram_addr_bit10_o)
    );

    // Clock enable low while sdram does not own the bus
    ebp_out_reg #(.W(4), .IDLE(`EBP_SDR_IDLE)) u_sdr (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     (next_sdr),
        .q_o     ({pin_sdram_ras_n_o, pin_sdram_cas_n_o, pin_sdram_we_n_o, pin_sdram_clk_en_o})
    );

    // Nand select itself rides on chip select three
    ebp_out_reg #(.W(2), .IDLE(`EBP_NAND_IDLE)) u_nand (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     (next_nand),
        .q_o     ({pin_nand_out_en_n_o, pin_nand_wr_en_n_o})
    );

    ebp_out_reg #(.W(3), .IDLE(`EBP_CARD_IDLE)) u_card (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     (next_card),
        .q_o     ({pin_card_io_read_n_o, pin_card_io_write_n_o, pin_card_read_not_write_o})
    );

    // =========================================================
    // Return path
    // Wait only reaches the static side; sdram timing has no wait input
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stc_rdata_o      <= '0;
            sdc_rdata_o      <= '0;
            stc_ext_wait_n_o <= 1'b1;
        end else begin
            stc_rdata_o      <= pin_data_i & width_mask;
            sdc_rdata_o      <= pin_data_i & width_mask;
            stc_ext_wait_n_o <= pin_ext_wait_n_i | (owner != EBP_OWN_STATIC);
        end
    end
endmodule
`default_nettype wire

// file: common/ebp_map.svh
// Constants for the external bus port pin multiplexer
// Behaviour
// - Data bus 16 or 32 bits, address 26 bits
// - Six active-low chip selects, one per space
// - Shared pins follow the controller owning the bus
// - Address pins map sdram or static address bits
// - Sdram row, column, write low; clock enable high
// - Active-low sdram chip select on shared chip select one
// - Separate sdram address bit ten output
// - Nand select, output and write enables active low
// - Card read, write strobes and direction output
// - Two card chip selects share general selects
`ifndef EBP_MAP_SVH
`define EBP_MAP_SVH
`define EBP_DATA_W      32
`define EBP_ADDR_W      26
`define EBP_NCS         6
`define EBP_SDR_ADDR_W  13
`define EBP_SEL_SDRAM   1
`define EBP_SEL_NAND    3
`define EBP_SEL_CARD0   4
`define EBP_SEL_CARD1   5
`define EBP_CS_IDLE     6'h3F
`define EBP_MASK_IDLE   4'hF
`define EBP_HALF_MASK   32'h0000_FFFF
`define EBP_SDR_IDLE    4'hE
`define EBP_NAND_IDLE   2'h3
`define EBP_CARD_IDLE   3'h7
`define EBP_STROBE_IDLE 5'h1F
`endif

// file: common/ebp_pkg.sv
// Types for the external bus port pin multiplexer
package ebp_pkg;
    typedef enum logic [1:0] {EBP_OWN_NONE, EBP_OWN_STATIC, EBP_OWN_SDRAM} ebp_owner_e;
endpackage

// file: hw/ebp_out_reg.sv
// Output flop with inactive reset value
`timescale 1ns/1ps
`default_nettype none
module ebp_out_reg #(
    parameter int          W    = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_o <= IDLE;
        end else begin
            q_o <= d_i;
        end
    end
endmodule
`default_nettype wire

// file: verification/ebp_pin_mux_asserts.sv
// Checker for the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module ebp_pin_mux_asserts (
    // Clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_b_i,
    // Configuration and ownership
    input wire logic        bus_wide_i,
    input wire logic        static_own_i,
    input wire logic        sdram_own_i,
    // Static controller side
    input wire logic [5:0]  stc_chip_select_n_i,
    input wire logic        stc_read_strobe_n_i,
    input wire logic        stc_nand_en_i,
    input wire logic        stc_card_en_i,
    input wire logic        stc_card_rd_i,
    // Sdram controller side
    input wire logic [12:0] sdc_addr_i,
    input wire logic        sdc_sel_n_i,
    input wire logic        sdc_ras_n_i,
    input wire logic        sdc_clk_en_i,
    // Pins
    input wire logic [25:0] pin_addr_o,
    input wire logic [31:0] pin_data_oe_o,
    input wire logic [5:0]  pin_chip_select_n_o,
    input wire logic        pin_read_strobe_n_o,
    input wire logic        pin_sdram_addr_bit10_o,
    input wire logic        pin_sdram_ras_n_o,
    input wire logic        pin_sdram_clk_en_o,
    input wire logic        pin_nand_out_en_n_o,
    input wire logic        pin_card_read_not_write_o
);
    logic [12:0] adq;
    logic        st;
    assign st = static_own_i && !sdram_own_i;
    // Copy kept here, since a slice of a past value is not legal
    always_ff @(posedge mclk_i) adq <= sdc_addr_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    property p_wid; !bus_wide_i |=> pin_data_oe_o[31:16] == 16'h0000; endproperty
    a_wid: assert property (p_wid) else $error("upper lanes driven");
    property p_scs; st |=> pin_chip_select_n_o == $past(stc_chip_select_n_i); endproperty
    a_scs: assert property (p_scs) else $error("static select wrong");
    property p_adr; sdram_own_i |=> pin_addr_o[11:2] == adq[9:0] && pin_addr_o[14:13] == adq[12:11]; endproperty
    a_adr: assert property (p_adr) else $error("sdram address wrong");
    property p_ras; sdram_own_i ##1 1'b1 |-> {pin_sdram_ras_n_o, pin_sdram_clk_en_o} == $past({sdc_ras_n_i, sdc_clk_en_i}); endproperty
    a_ras: assert property (p_ras) else $error("sdram strobe wrong");
    property p_sel; sdram_own_i |=> pin_chip_select_n_o == {4'hF, $past(sdc_sel_n_i), 1'b1}; endproperty
    a_sel: assert property (p_sel) else $error("sdram select wrong");
    property p_a10; sdram_own_i |=> pin_sdram_addr_bit10_o == adq[10]; endproperty
    a_a10: assert property (p_a10) else $error("address ten wrong");
    property p_nnd; st && stc_nand_en_i |=> pin_nand_out_en_n_o == $past(stc_read_strobe_n_i); endproperty
    a_nnd: assert property (p_nnd) else $error("nand enable wrong");
    property p_crd; st && stc_card_en_i |=> pin_card_read_not_write_o == $past(stc_card_rd_i); endproperty
    a_crd: assert property (p_crd) else $error("card direction wrong");
    property p_idl; !static_own_i && !sdram_own_i |-> ##1 pin_chip_select_n_o == 6'h3F
        && pin_read_strobe_n_o && pin_sdram_ras_n_o && !pin_sdram_clk_en_o; endproperty
    a_idl: assert property (p_idl) else $error("idle level wrong");
endmodule
bind ebp_pin_mux ebp_pin_mux_asserts u_asserts (.*);
`default_nettype wire

// file: verification/ebp_ext_dev.sv
// Behavioural external device on the far side of the bus port
`timescale 1ns/1ps
`default_nettype none
module ebp_ext_dev #(
    parameter logic [31:0] RD_DATA = 32'h0000_0001
) (
    // Clock and speed choice
    input  wire logic        mclk_i,
    input  wire logic        slow_i,
    // Pins from the bus port
    input  wire logic        pin_read_strobe_n_o,
    input  wire logic [5:0]  pin_chip_select_n_o,
    input  wire logic [31:0] pin_data_oe_o,
    // Pins into the bus port
    output logic      [31:0] pin_data_i,
    output logic             pin_ext_wait_n_i
);
    logic [31:0] junk;
    logic        rd;
    assign rd = !pin_read_strobe_n_o && pin_chip_select_n_o != 6'h3F && pin_data_oe_o == 32'h0;
    // Released bus toggles so stale data never passes for a read
    initial junk = 32'h0F0F_0F0F;
    always @(posedge mclk_i) junk <= ~junk;
    assign pin_data_i = rd ? RD_DATA : junk;
    assign pin_ext_wait_n_i = !(rd && slow_i);
endmodule
`default_nettype wire

// file: verification/test_ebp_pin_mux.sv
// Self-checking bench for the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module test_ebp_pin_mux;
    logic        mclk_i, rst_b_i, bus_wide_i, static_own_i, sdram_own_i, stc_read_strobe_n_i, stc_upper_byte_n_i;
    logic        stc_lower_byte_n_i, stc_drive_i, stc_nand_en_i, stc_card_en_i, stc_card_rd_i, stc_ext_wait_n_o;
    logic        sdc_sel_n_i, sdc_ras_n_i, sdc_cas_n_i, sdc_we_n_i, sdc_clk_en_i, sdc_drive_i, pin_ext_wait_n_i;
    logic        pin_read_strobe_n_o, pin_sdram_addr_bit10_o, pin_sdram_ras_n_o, pin_sdram_cas_n_o, pin_sdram_we_n_o;
    logic        pin_sdram_clk_en_o, pin_nand_out_en_n_o, pin_nand_wr_en_n_o, pin_card_io_read_n_o, slow_i;
    logic        pin_card_io_write_n_o, pin_card_read_not_write_o;
    logic [25:0] stc_addr_i, pin_addr_o;
    logic [12:0] sdc_addr_i;
    logic [5:0]  stc_chip_select_n_i, pin_chip_select_n_o;
    logic [3:0]  stc_byte_write_n_i, sdc_byte_mask_n_i, pin_byte_write_n_o;
    logic [1:0]  sdc_bank_i;
    logic [31:0] stc_wdata_i, sdc_wdata_i, stc_rdata_o, sdc_rdata_o, pin_data_o, pin_data_oe_o, pin_data_i;
    int          mismatches, tests_run;
    localparam logic [31:0] RD = 32'hC3A5_5A3C;
    ebp_pin_mux dut (.*);
    ebp_ext_dev #(.RD_DATA(RD)) dev (.*);
    task step(int n); repeat (n) @(posedge mclk_i); #1; endtask
    task chk(logic [31:0] g, logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask
    task summarize;
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Sdram wins over static; static select must not leak
    task sdram_t;
        {sdram_own_i, static_own_i, stc_chip_select_n_i, sdc_addr_i, sdc_bank_i} = {2'b11, 6'h00, 13'h1EBC, 2'h2};
        {sdc_byte_mask_n_i, sdc_sel_n_i, sdc_ras_n_i, sdc_cas_n_i, sdc_we_n_i, sdc_clk_en_i} = 9'b0101_0_0101;
        {sdc_drive_i, sdc_wdata_i} = {1'b1, 32'h89AB_CDEF};
        step(1);
        chk(pin_addr_o[11:2], 10'h2BC);
        chk({pin_addr_o[14:13], pin_addr_o[1:0]}, 4'b1111);
        chk(pin_addr_o[17:16], 2'h2);
        chk(pin_byte_write_n_o, 4'h5);
        chk(pin_sdram_addr_bit10_o, 1'b1);
        chk({pin_sdram_ras_n_o, pin_sdram_cas_n_o, pin_sdram_we_n_o, pin_sdram_clk_en_o}, 4'b0101);
        chk(pin_chip_select_n_o, 6'h3D);
        chk(pin_data_o, 32'h89AB_CDEF);
        chk(pin_data_oe_o, 32'hFFFF_FFFF);
        {sdc_ras_n_i, sdc_drive_i} = 2'b10;
        step(1);
        chk(pin_sdram_ras_n_o, 1'b1);
        chk(pin_data_oe_o, 32'h0000_0000);
    endtask
    task static_t;
        {sdram_own_i, static_own_i, stc_addr_i, stc_lower_byte_n_i, stc_upper_byte_n_i} = {2'b01, 26'h3ABCDEF, 2'b00};
        {stc_chip_select_n_i, stc_byte_write_n_i, stc_read_strobe_n_i, sdc_ras_n_i} = {6'h3E, 4'hA, 2'b00};
        step(1);
        chk(pin_addr_o, 26'h3ABCDEE);
        chk({pin_chip_select_n_o, pin_byte_write_n_o}, {6'h3E, 4'h8});
        chk({pin_read_strobe_n_o, pin_sdram_ras_n_o}, 2'b01);
    endtask
    task nand_card_t;
        {stc_nand_en_i, stc_byte_write_n_i, stc_chip_select_n_i} = {1'b1, 4'hE, 6'h37};
        step(1);
        chk({pin_nand_out_en_n_o, pin_nand_wr_en_n_o, pin_chip_select_n_o}, {2'b00, 6'h37});
        {stc_nand_en_i, stc_card_en_i, stc_card_rd_i, stc_read_strobe_n_i, stc_chip_select_n_i} = {4'b0111, 6'h1F};
        step(1);
        chk({pin_card_io_read_n_o, pin_card_io_write_n_o, pin_card_read_not_write_o}, 3'b101);
        chk(pin_chip_select_n_o, 6'h1F);
        chk({pin_nand_out_en_n_o, pin_nand_wr_en_n_o}, 2'b11);
        stc_card_en_i = 0;
    endtask
    task idle_t;
        {static_own_i, stc_chip_select_n_i, stc_read_strobe_n_i, sdc_ras_n_i, sdc_clk_en_i} = {7'h00, 3'b001};
        step(1);
        chk({pin_chip_select_n_o, pin_read_strobe_n_o, pin_sdram_ras_n_o, pin_sdram_clk_en_o}, 9'h1FE);
    endtask
    // Narrow write, slow narrow read, then wide read
    task width_t;
        {static_own_i, bus_wide_i, stc_drive_i, stc_wdata_i, stc_read_strobe_n_i} = {3'b101, 32'h1234_5678, 1'b1};
        step(1);
        chk(pin_data_oe_o, 32'h0000_FFFF);
        chk(pin_data_o, 32'h0000_5678);
        {stc_drive_i, stc_read_strobe_n_i, stc_chip_select_n_i, slow_i} = {2'b00, 6'h3E, 1'b1};
        step(2);
        chk(stc_rdata_o, RD & 32'h0000_FFFF);
        chk(sdc_rdata_o, RD & 32'h0000_FFFF);
        chk(stc_ext_wait_n_o, 1'b0);
        {bus_wide_i, slow_i} = 2'b10;
        step(2);
        chk(stc_rdata_o, RD);
        chk(sdc_rdata_o, RD);
        chk(stc_ext_wait_n_o, 1'b1);
    endtask
    initial begin
        mclk_i = 0;
        forever #10 mclk_i = ~mclk_i;
    end
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        {rst_b_i, static_own_i, sdram_own_i, stc_drive_i, stc_nand_en_i, stc_card_en_i, stc_card_rd_i} = '0;
        {sdc_clk_en_i, sdc_drive_i, stc_addr_i, stc_wdata_i, sdc_wdata_i, sdc_addr_i, sdc_bank_i, slow_i} = '0;
        {bus_wide_i, stc_read_strobe_n_i, stc_upper_byte_n_i, stc_lower_byte_n_i, sdc_sel_n_i, sdc_ras_n_i} = '1;
        {sdc_cas_n_i, sdc_we_n_i, stc_chip_select_n_i, stc_byte_write_n_i, sdc_byte_mask_n_i} = '1;
        step(5);
        rst_b_i = 1;
        step(1);
        sdram_t();
        static_t();
        nand_card_t();
        idle_t();
        width_t();
        sdram_t();
        rst_b_i = 0;
        step(1);
        chk({pin_chip_select_n_o, pin_sdram_ras_n_o, pin_sdram_clk_en_o}, 8'hFE);
        summarize();
    end
endmodule
`default_nettype wire
